// ---- logic/lfc_top.sv ----
/*
  lfc_top: lift platform enable controller with an AXI4-Lite register slave.
  Assumes switch, fob and key pins are asynchronous; speed, voltage and current
  codes come from converters on clk. lift_enable drives the battery protection
  module, which closes the motor power switch.
*/
// Register access over AXI4-Lite and the register addresses were decided locally.
// Notes on behaviour
// - press on or fob, under 2 mph, voltage good: enable for programmed time
// - rocker off press disables in rocker mode only; in push-button mode a button press toggles off
// - fob press while enabled disables
// - low voltage disables after override time, or at once above 2 mph
// - enable ends when the programmed time has elapsed
// - enable time is 10-minute units, 1 to 24, default 6
// - activation after a timeout enables for ten more minutes
// - above 2 mph disable and flash the switch lamp
// - after speed disable stay off until a fresh activation at standstill
// - lamp lit steadily while enabled
// - voltage watch runs in every key position including off
// - buzzer on low voltage only with key neither off nor start
// - disable threshold 11.5 to 13.8 V in 0.1 V codes, default 11.5
// - low-voltage operating time 1 to 120 s, default 60
// - alarm when current exceeds high level, 0 to 10 A, default 10
// - alarm when current falls below low level, default 0.3 A
// - alarm when current falls below open-circuit level, default 0.3 A
// - enable output drives the battery protection module
module lfc_top
  import lfc_pkg::*;
#(
  parameter int unsigned TICK = lfc_pkg::TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sw_on,
  input  wire logic       sw_off,
  input  wire logic       sw_push,
  input  wire logic       fob_aux,
  input  wire logic [1:0] key_pos,
  input  wire logic [7:0] road_speed,
  input  wire logic [7:0] battery_volts,
  input  wire logic [7:0] motor_amps,
  output logic            lift_enable,
  output logic            lamp,
  output logic            buzzer,
  output logic            irq,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready
);
  import lfc_pkg::*;

  // elaboration checks: the divider needs two states, the counters must hold the
  // longest programmable times, and resets must sit inside their ranges
  if (TICK < 2) begin : g_bad_tick
    $error("lfc_top: TICK below 2");
  end
  if (UNITS_MAX * UNIT_S > 16'hFFFF || EXTEND_S > 16'hFFFF) begin : g_bad_time
    $error("lfc_top: enable time too long");
  end
  if (P_KEY0 + 2 != PIN_W) begin : g_bad_pins
    $error("lfc_top: pin layout");
  end
  if (EV_TIMEOUT != 0 || EV_HI != 3 || EV_OC != IRQ_W - 1) begin : g_bad_events
    $error("lfc_top: event layout");
  end
  if (UNITS_RST < UNITS_MIN || UNITS_RST > UNITS_MAX ||
      ALARM_RST < ALARM_MIN || ALARM_RST > ALARM_MAX) begin : g_bad_timers
    $error("lfc_top: timer reset out of range");
  end
  if (VTH_RST < VTH_MIN || VTH_RST > VTH_MAX ||
      HI_RST > AMP_MAX || LO_RST > AMP_MAX || OC_RST > AMP_MAX) begin : g_bad_levels
    $error("lfc_top: level reset out of range");
  end

  logic [PIN_W-1:0]  pins;
  logic [PIN_W-1:0]  s1, s2, s3, filt, filt_q;
  logic [31:0]       tick_cnt;
  logic              tick, flash;
  logic              pb_mode;
  logic [7:0]        units, alarm_s, vth, hi_lvl, lo_lvl, oc_lvl;
  logic [IRQ_W-1:0]  irq_stat, irq_mask, ev;
  logic [2:0]        ev_seq, ev_cur;
  lfc_state_e        st;
  logic [15:0]       en_left;
  logic [7:0]        lv_left;
  logic              timed_out;
  logic              on_edge, off_edge, push_edge, fob_edge;
  logic              moving, stopped, low_v, key_live;
  logic              act, man_off;
  logic              hi_c, lo_c, oc_c, hi_q, lo_q, oc_q;
  logic              aw_hold, w_hold;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [IRQ_W-1:0]  w1c;
  logic [31:0]       rd_word;
  logic              rd_hit;

  assign pins = {key_pos, fob_aux, sw_push, sw_off, sw_on};

  // sequencer and current events own separate halves, so each has one driver
  assign ev = {ev_cur, ev_seq};

  // three-stage synchronisers; the filtered level moves only when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1[gi]     <= 1'b0;
          s2[gi]     <= 1'b0;
          s3[gi]     <= 1'b0;
          filt[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1[gi]     <= pins[gi];
          s2[gi]     <= s1[gi];
          s3[gi]     <= s2[gi];
          if (s2[gi] == s3[gi]) filt[gi] <= s3[gi];
          filt_q[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  // press detection on the filtered levels
  assign on_edge   = filt[P_ON] & ~filt_q[P_ON];
  assign off_edge  = filt[P_OFF] & ~filt_q[P_OFF];
  assign push_edge = filt[P_PUSH] & ~filt_q[P_PUSH];
  assign fob_edge  = filt[P_FOB] & ~filt_q[P_FOB];
  assign key_live  = (filt[P_KEY0+:2] != KEY_OFF) && (filt[P_KEY0+:2] != KEY_START);

  // operating conditions from the converter codes; a speed code of exactly the
  // limit neither enables nor locks, a small dead band against chatter
  assign moving  = road_speed > SPEED_LIMIT;
  assign stopped = road_speed < SPEED_LIMIT;
  assign low_v   = battery_volts < vth;
  assign hi_c    = motor_amps > hi_lvl;
  assign lo_c    = motor_amps < lo_lvl;
  assign oc_c    = motor_amps < oc_lvl;

  // activation requests; in push-button mode one button both turns on and off
  assign act = (on_edge | fob_edge | (pb_mode & push_edge)) & stopped & ~low_v;
  assign man_off = (~pb_mode & off_edge) | (pb_mode & push_edge) | fob_edge;

  // one-second time base; all long timers count these ticks
  // the tick is registered, so timers see it one cycle after the divider wraps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK - 1);
      tick_cnt <= (tick_cnt == TICK - 1) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // enable sequencer; while on, a disable cause beats a same-cycle activation; while off, an activation wins over a same-cycle off press
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st        <= LFC_OFF;
      en_left   <= 16'h0;
      lv_left   <= ALARM_RST;
      timed_out <= 1'b0;
      ev_seq    <= 3'h0;
    end else begin
      ev_seq <= 3'h0;
      unique case (st)
        LFC_ON: begin
          if (moving) begin
            st <= LFC_LOCK;
            timed_out <= 1'b0;
            ev_seq[EV_SPEED] <= 1'b1;
          end else if (man_off) begin
            st <= LFC_OFF;
            timed_out <= 1'b0;
          end else if (low_v && tick && lv_left <= 8'h1) begin
            st <= LFC_OFF;
            timed_out <= 1'b0;
            ev_seq[EV_LOWV] <= 1'b1;
          end else if (tick && en_left <= 16'h1) begin
            st <= LFC_OFF;
            timed_out <= 1'b1;
            ev_seq[EV_TIMEOUT] <= 1'b1;
          end else if (tick) begin
            en_left <= en_left - 16'h1;
            if (low_v) lv_left <= lv_left - 8'h1;
          end
          // recovered voltage reloads the override time, so a brief sag is forgiven
          if (!low_v) lv_left <= alarm_s;
        end
        default: begin
          // off or speed-locked: timers stand still until a fresh activation
          if (act) begin
            st      <= LFC_ON;
            lv_left <= alarm_s;
            en_left <= timed_out ? 16'(EXTEND_S)
                                 : 16'(units * UNIT_S);
          end
        end
      endcase
    end
  end

  // current alarms fire once as each condition appears while powered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
      oc_q <= 1'b0;
      ev_cur <= 3'h0;
    end else begin
      hi_q <= hi_c & (st == LFC_ON);
      lo_q <= lo_c & (st == LFC_ON);
      oc_q <= oc_c & (st == LFC_ON);
      ev_cur[EV_HI - 3] <= hi_c & (st == LFC_ON) & ~hi_q;
      ev_cur[EV_LO - 3] <= lo_c & (st == LFC_ON) & ~lo_q;
      ev_cur[EV_OC - 3] <= oc_c & (st == LFC_ON) & ~oc_q;
    end
  end

  // pin outputs, each from its own flip-flop
  // the lamp toggles on every tick while speed-locked, a two-tick flash
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash       <= 1'b0;
      lift_enable <= 1'b0;
      lamp        <= 1'b0;
      buzzer      <= 1'b0;
      irq         <= 1'b0;
    end else begin
      if (tick) flash <= ~flash;
      lift_enable <= (st == LFC_ON);
      lamp        <= (st == LFC_ON) | ((st == LFC_LOCK) & flash);
      buzzer      <= low_v & key_live & (st == LFC_ON);
      irq         <= |(irq_stat & irq_mask);
    end
  end

  // axi write path: address and data taken in either order, answered once both are held
  // the ready pulses stop a valid that is still held from being taken twice
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_hold & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_hold & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:2] <= OFS_IRQ_MASK[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // clamp helper keeps programmed values inside their legal range
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // configuration registers; out-of-range writes saturate rather than fault
  // byte strobes are honoured per field, so one field can change alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pb_mode  <= 1'b0;
      units    <= UNITS_RST;
      alarm_s  <= ALARM_RST;
      vth      <= VTH_RST;
      hi_lvl   <= HI_RST;
      lo_lvl   <= LO_RST;
      oc_lvl   <= OC_RST;
      irq_mask <= '0;
    end else if (do_write) begin
      if (aw_addr[7:2] == OFS_CTRL[7:2]) begin
        if (w_strb[0]) pb_mode <= w_data[CTRL_PB];
        if (w_strb[1]) units   <= clamp(w_data[CTRL_UNITS+:8], UNITS_MIN, UNITS_MAX);
        if (w_strb[2]) alarm_s <= clamp(w_data[CTRL_ALARM+:8], ALARM_MIN, ALARM_MAX);
      end
      if (aw_addr[7:2] == OFS_VTH[7:2] && w_strb[0]) begin
        vth <= clamp(w_data[7:0], VTH_MIN, VTH_MAX);
      end
      if (aw_addr[7:2] == OFS_AMPS[7:2]) begin
        if (w_strb[0]) hi_lvl <= clamp(w_data[AMPS_HI+:8], 8'h0, AMP_MAX);
        if (w_strb[1]) lo_lvl <= clamp(w_data[AMPS_LO+:8], 8'h0, AMP_MAX);
        if (w_strb[2]) oc_lvl <= clamp(w_data[AMPS_OC+:8], 8'h0, AMP_MAX);
      end
      if (aw_addr[7:2] == OFS_IRQ_MASK[7:2] && w_strb[0]) irq_mask <= w_data[IRQ_W-1:0];
    end
  end

  // sticky event bits: writing one clears, a new event in that cycle wins
  assign w1c = (do_write && aw_addr[7:2] == OFS_IRQ_STAT[7:2] && w_strb[0]) ? w_data[IRQ_W-1:0] : '0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | ev;
    end
  end

  // read mux
  // reads have no side effects, so a repeated read is harmless
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr[7:2])
      OFS_CTRL[7:2]:     rd_word = {8'h0, alarm_s, units, 7'h0, pb_mode};
      OFS_VTH[7:2]:      rd_word = {24'h0, vth};
      OFS_AMPS[7:2]:     rd_word = {8'h0, oc_lvl, lo_lvl, hi_lvl};
      OFS_STATUS[7:2]:   rd_word = {24'h0, 1'b0, hi_q | lo_q | oc_q, buzzer, timed_out,
                                    low_v, st == LFC_LOCK, lamp, st == LFC_ON};
      OFS_IRQ_STAT[7:2]: rd_word = {26'h0, irq_stat};
      OFS_IRQ_MASK[7:2]: rd_word = {26'h0, irq_mask};
      default:           rd_hit  = 1'b0;
    endcase
  end

  // axi read path: one cycle to accept, data on the next
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : lfc_top

// ---- logic/lfc_pkg.sv ----
/*
  lfc_pkg: constants shared by the lift platform enable controller.
  Assumes a 125 MHz system clock; analog readings arrive as 0.1-unit codes.
*/
package lfc_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_MS       = 1000;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned UNIT_MIN      = 10;
  localparam int unsigned UNIT_S        = UNIT_MIN * 60;
  localparam int unsigned EXTEND_MIN    = 10;
  localparam int unsigned EXTEND_S      = EXTEND_MIN * 60;
  // speed interlock, 0.1 mph per code
  localparam logic [7:0]  SPEED_LIMIT   = 8'h14;
  // programmable ranges and defaults
  localparam logic [7:0]  UNITS_MIN     = 8'h01;
  localparam logic [7:0]  UNITS_MAX     = 8'h18;
  localparam logic [7:0]  UNITS_RST     = 8'h06;
  localparam logic [7:0]  ALARM_MIN     = 8'h01;
  localparam logic [7:0]  ALARM_MAX     = 8'h78;
  localparam logic [7:0]  ALARM_RST     = 8'h3C;
  localparam logic [7:0]  VTH_MIN       = 8'h73;
  localparam logic [7:0]  VTH_MAX       = 8'h8A;
  localparam logic [7:0]  VTH_RST       = 8'h73;
  localparam logic [7:0]  AMP_MAX       = 8'h64;
  localparam logic [7:0]  HI_RST        = 8'h64;
  localparam logic [7:0]  LO_RST        = 8'h03;
  localparam logic [7:0]  OC_RST        = 8'h03;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_VTH       = 8'h04;
  localparam logic [7:0]  OFS_AMPS      = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
  // field positions
  localparam int unsigned CTRL_PB       = 0;
  localparam int unsigned CTRL_UNITS    = 8;
  localparam int unsigned CTRL_ALARM    = 16;
  localparam int unsigned AMPS_HI       = 0;
  localparam int unsigned AMPS_LO       = 8;
  localparam int unsigned AMPS_OC       = 16;
  // interrupt bits
  localparam int unsigned IRQ_W         = 6;
  localparam int unsigned EV_TIMEOUT    = 0;
  localparam int unsigned EV_SPEED      = 1;
  localparam int unsigned EV_LOWV       = 2;
  localparam int unsigned EV_HI         = 3;
  localparam int unsigned EV_LO         = 4;
  localparam int unsigned EV_OC         = 5;
  // key positions
  localparam logic [1:0]  KEY_OFF       = 2'h0;
  localparam logic [1:0]  KEY_START     = 2'h3;
  // axi responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // synchronised pin vector layout
  localparam int unsigned PIN_W         = 6;
  localparam int unsigned P_ON          = 0;
  localparam int unsigned P_OFF         = 1;
  localparam int unsigned P_PUSH        = 2;
  localparam int unsigned P_FOB         = 3;
  localparam int unsigned P_KEY0        = 4;
  typedef enum logic [1:0] {LFC_OFF, LFC_ON, LFC_LOCK} lfc_state_e;
endpackage : lfc_pkg

// ---- sim/lfc_top_props.sv ----
/*
  lfc_top_props: port-level assertions for lfc_top, bound into every instance.
  Assumes one clk domain with synchronous active-low rst_n.
*/
module lfc_top_props
  import lfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [1:0]  key_pos,
  input wire logic [7:0]  road_speed,
  input wire logic [7:0]  battery_volts,
  input wire logic        lift_enable,
  input wire logic        lamp,
  input wire logic        buzzer,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decision is taken two edges before the output rises
  a_rise_slow: assert property ($rose(lift_enable) |-> $past(road_speed, 2) < SPEED_LIMIT)
    else $error("enable rose while moving");
  // lowest legal threshold bounds every setting
  a_rise_volts: assert property ($rose(lift_enable) |-> $past(battery_volts, 2) >= VTH_MIN)
    else $error("enable rose on low battery");
  a_speed_drop: assert property ((road_speed > SPEED_LIMIT) [*3] |-> !lift_enable)
    else $error("enable kept above speed limit");
  a_lamp_steady: assert property (lift_enable |-> lamp)
    else $error("lamp dark while enabled");
  // key goes through a synchroniser, so only judge a settled key
  a_buzz_key: assert property (buzzer && $past(key_pos, 8) == key_pos |-> key_pos != KEY_OFF && key_pos != KEY_START)
    else $error("buzzer in off or start");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than a pulse");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > OFS_IRQ_MASK[7:2] |=>
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_drop: cover property ($fell(lift_enable));
  c_buzz: cover property (buzzer);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : lfc_top_props

bind lfc_top lfc_top_props lfc_top_props_i (.clk, .rst_n, .key_pos, .road_speed, .battery_volts, .lift_enable,
  .lamp, .buzzer, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- sim/lfc_bpm.sv ----
/*
  lfc_bpm: behavioural protection module closing the motor power switch.
  Assumes lift_enable is a registered level on clk.
*/
module lfc_bpm #(
  parameter int DLY = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic lift_enable,
  output logic      mag_closed
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  // closes DLY+1 cycles late like a real coil; opens at once, safer than lagging
  always_ff @(posedge clk) begin
    if (!rst_n || !lift_enable) begin
      cnt <= 8'h00;
      mag_closed <= 1'b0;
    end else if (cnt >= DLY) begin
      mag_closed <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : lfc_bpm

// ---- sim/lfc_top_tb.sv ----
/*
  lfc_top_tb: self-checking bench for lfc_top with its protection module partner.
  Assumes TICK shortened to TK cycles; all times scale from it.
*/
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module lfc_top_tb
  import lfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 2;
  logic        clk = 1'b0;
  logic        rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        lift_enable, lamp, buzzer, irq, mag_closed, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, lamp0;
  logic [1:0]  key_pos, s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [3:0]  pins, s_axi_wstrb;
  logic [7:0]  road_speed, battery_volts, motor_amps, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  int          mismatches, comparisons, n;

  always #4 clk = ~clk;

  lfc_top #(.TICK(TK)) lfc_top_i (.clk, .rst_n, .sw_on(pins[0]), .sw_off(pins[1]), .sw_push(pins[2]),
    .fob_aux(pins[3]), .key_pos, .road_speed, .battery_volts, .motor_amps, .lift_enable, .lamp, .buzzer, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lfc_bpm #(.DLY(3)) lfc_bpm_i (.clk, .rst_n, .lift_enable, .mag_closed);

  // ready and answers are read at the handshake edge, before its own updates land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    rb = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!rb) begin
      @(posedge clk);
      {ra, rw, rb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rb) s_axi_bready <= 1'b0;
      if (rb) wr_resp = s_axi_bresp;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ra, rv;
    rv = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!rv) begin
      @(posedge clk);
      {ra, rv, rd_data, rd_resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      if (ra) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
    end
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rd_data & m)
  endtask : rdc
  task automatic press(input int i);
    @(posedge clk);
    pins[i] <= 1'b1;
    repeat (8) @(posedge clk);
    pins[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
  task automatic wait_en(input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lift_enable !== v && n < lim);
  endtask : wait_en

  task automatic t_regs;
    rdc(OFS_CTRL, 32'hFFFFFFFF, 32'h003C0600, "ctrl reset");
    rdc(OFS_VTH, 32'hFFFFFFFF, 32'h00000073, "vth reset");
    rdc(OFS_AMPS, 32'hFFFFFFFF, 32'h00030364, "amps reset");
    rdc(OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h00000000, "mask reset");
    rd(8'h18);
    `CHK("unmapped resp", RESP_SLVERR, rd_resp)
    wr(8'h18, 32'h00000000);
    `CHK("unmapped write", RESP_SLVERR, wr_resp)
    wr(OFS_CTRL, 32'h003C2000);
    rdc(OFS_CTRL, 32'h0000FF00, 32'h00001800, "units clamp");
    s_axi_wstrb <= 4'h2;
    wr(OFS_CTRL, 32'h00FF0301);
    s_axi_wstrb <= 4'hF;
    rdc(OFS_CTRL, 32'h00FFFFFF, 32'h003C0300, "strobe lanes");
    wr(OFS_VTH, 32'h00000050);
    rdc(OFS_VTH, 32'h000000FF, 32'h00000073, "vth clamp");
    wr(OFS_CTRL, 32'h003C0200);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_enable;
    press(0);
    `CHK("enable", 1'b1, lift_enable)
    `CHK("lamp on", 1'b1, lamp)
    `CHK("switch closed", 1'b1, mag_closed)
    motor_amps <= 8'h65;
    repeat (4) @(posedge clk);
    motor_amps <= 8'h01;
    repeat (4) @(posedge clk);
    motor_amps <= 8'h32;
    rdc(OFS_IRQ_STAT, 32'h00000038, 32'h00000038, "current alarms");
    wr(OFS_IRQ_STAT, 32'h00000038);
    press(3);
    `CHK("fob off", 1'b0, lift_enable)
    `CHK("lamp off", 1'b0, lamp)
    `CHK("switch open", 1'b0, mag_closed)
    $display("t_enable done");
  endtask : t_enable
  task automatic t_timeout;
    press(0);
    wait_en(0, 5000);
    `CHK("units time", 1'b1, n > 2 * 600 * TK - 24 && n < 2 * 600 * TK + 8)
    `CHK("masked irq", 1'b0, irq)
    rdc(OFS_IRQ_STAT, 32'h00000001, 32'h00000001, "timeout stat");
    wr(OFS_IRQ_MASK, 32'h00000001);
    repeat (4) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    wr(OFS_IRQ_STAT, 32'h00000001);
    repeat (4) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    press(0);
    wait_en(0, 3000);
    `CHK("extension", 1'b1, n > 600 * TK - 24 && n < 600 * TK + 8)
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_speed;
    press(0);
    road_speed <= 8'h15;
    wait_en(0, 10);
    `CHK("speed off", 1'b0, lift_enable)
    lamp0 = lamp;
    repeat (TK + 1) @(posedge clk);
    `CHK("lamp flash", ~lamp0, lamp)
    rdc(OFS_STATUS, 32'h00000005, 32'h00000004, "status lock");
    road_speed <= 8'h00;
    repeat (30) @(posedge clk);
    `CHK("no resume", 1'b0, lift_enable)
    press(0);
    `CHK("fresh press", 1'b1, lift_enable)
    press(1);
    `CHK("rocker off", 1'b0, lift_enable)
    `CHK("lamp dark", 1'b0, lamp)
    $display("t_speed done");
  endtask : t_speed
  task automatic t_lowv;
    key_pos <= 2'h1;
    press(0);
    battery_volts <= 8'h64;
    repeat (10) @(posedge clk);
    `CHK("buzzer run", 1'b1, buzzer)
    wait_en(0, 60 * TK + 40);
    `CHK("lowv off", 1'b0, lift_enable)
    `CHK("override time", 1'b1, n > 60 * TK - 30)
    press(0);
    `CHK("refused", 1'b0, lift_enable)
    battery_volts <= 8'h7D;
    key_pos <= KEY_OFF;
    press(0);
    battery_volts <= 8'h64;
    repeat (10) @(posedge clk);
    `CHK("buzzer key off", 1'b0, buzzer)
    wait_en(0, 60 * TK + 40);
    `CHK("key off shutdown", 1'b0, lift_enable)
    battery_volts <= 8'h7D;
    $display("t_lowv done");
  endtask : t_lowv
  task automatic t_push;
    wr(OFS_CTRL, 32'h003C0201);
    press(3);
    `CHK("fob on", 1'b1, lift_enable)
    press(2);
    `CHK("push off", 1'b0, lift_enable)
    $display("t_push done");
  endtask : t_push

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // main sequence
  initial begin
    {rst_n, pins, key_pos, road_speed, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    battery_volts = 8'h7D;
    motor_amps = 8'h32;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_enable();
    t_timeout();
    t_speed();
    t_lowv();
    t_push();
    test_done();
  end
  // tests need about 4300 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule : lfc_top_tb
